// *** hdl/tts_pkg.sv ***
// package of constants and carrier types for the trigger timestamp and adc packer
// assumes one 100 MHz master clock and a word-wide register port
package tts_pkg;

  // ----------------------------------------
  // clock and time base
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam logic [31:0] MASTER_CLOCK_X16_HZ = 32'(CLK_HZ * 16);
  localparam int unsigned MOD_CLKS_PER_ENTRY = 4;
  localparam int unsigned TRIG_PRESCALE = 4;
  localparam int unsigned ADC_WORD_CLKS = 4;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TABLE_LEN = 8'h04;
  localparam logic [7:0] OFS_FRAMES_PER_BLOCK = 8'h08;
  localparam logic [7:0] OFS_TRIG_DIV = 8'h0C;
  localparam logic [7:0] OFS_ADC_CYCLES = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h18;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h1C;
  localparam logic [7:0] OFS_FRAME_LO = 8'h20;
  localparam logic [7:0] OFS_FRAME_HI = 8'h24;
  localparam logic [7:0] OFS_TRIG_COUNT = 8'h28;
  localparam logic [7:0] OFS_CLK_X16 = 8'h2C;
  localparam logic [7:0] OFS_STATE = 8'h30;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned CTRL_MODE_LSB = 1;
  localparam int unsigned CTRL_TWO_PULSE_BIT = 3;
  localparam int unsigned CTRL_ADC_ARM_BIT = 4;
  localparam int unsigned IRQ_BLOCK_BIT = 0;
  localparam int unsigned IRQ_TRIGGER_BIT = 1;
  localparam int unsigned IRQ_ADC_DONE_BIT = 2;
  localparam int unsigned IRQ_W = 3;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [15:0] TABLE_LEN_RST = 16'h0019;
  localparam logic [31:0] FRAMES_PER_BLOCK_RST = 32'h0000_0400;
  localparam logic [15:0] TRIG_DIV_RST = 16'h0018;
  localparam logic [31:0] ADC_CYCLES_RST = 32'h0000_0010;

  // ----------------------------------------
  // modes and states
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_RAW = 2'h1,
    MODE_ADC = 2'h3
  } tts_mode_t;

  typedef enum logic [1:0] {
    ACQ_IDLE = 2'h0,
    ACQ_WAIT = 2'h1,
    ACQ_RUN = 2'h3
  } tts_acq_t;

  typedef enum logic [1:0] {
    ADC_IDLE = 2'h0,
    ADC_ARMED = 2'h1,
    ADC_CAPT = 2'h3
  } tts_adc_st_t;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic pulse_en;
    logic slope;
    logic out_of_range;
    logic [13:0] value;
  } tts_adc_smp_t;

  typedef struct packed {
    logic [31:0] master_clock_x16_hz;
    logic [15:0] timing_table_length;
    logic [1:0] pulses_per_pass;
    logic [31:0] frames_per_block;
  } tts_header_t;

  typedef struct packed {
    logic [63:0] first_frame_index;
    logic trigger_seen_flag;
    logic [31:0] trigger_timestamp;
  } tts_block_t;

endpackage

// *** hdl/tts_adc_pack.sv ***
// packs two adc samples, two clocks apart, into one 32-bit word
// assumes samples arrive on the master clock from the timing table
`timescale 1ns/1ps
`default_nettype none
module tts_adc_pack (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control
  input wire logic enable,
  // sample feed
  input wire tts_pkg::tts_adc_smp_t smp,
  // packed word
  output logic word_valid,
  output logic [31:0] word
);

  logic [1:0] phase_q;
  logic [15:0] low_q;
  logic valid_q;
  logic [31:0] word_q;
  wire take_first = enable && (phase_q == 2'h0);
  wire take_second = enable && (phase_q == 2'h2);

  // 50 MHz sampling from a 100 MHz clock: two samples per four clocks
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phase_q <= 2'h0;
      low_q <= 16'h0000;
      valid_q <= 1'b0;
      word_q <= 32'h0000_0000;
    end else begin
      phase_q <= enable ? phase_q + 2'h1 : 2'h0;
      valid_q <= take_second;
      if (take_first) begin
        low_q <= {smp.slope, smp.out_of_range, smp.value};
      end
      if (take_second) begin
        word_q <= {smp.pulse_en, smp.out_of_range, smp.value, low_q};
      end
    end
  end

  assign word_valid = valid_q;
  assign word = word_q;

endmodule
`default_nettype wire

// *** hdl/tts_top.sv ***
// frame and block timekeeping, trigger timestamping and adc word packing
// assumes trigger_in is an asynchronous pin; adc feed is on clk
`timescale 1ns/1ps
`default_nettype none

module tts_top (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // trigger pin
  input wire logic trigger_in,
  // adc feed from the timing table
  input wire tts_pkg::tts_adc_smp_t adc_in,
  // stream timing
  output logic frame_strobe,
  output logic pulse_strobe,
  output logic raw_pair_sel,
  // stream records
  output logic header_valid,
  output tts_pkg::tts_header_t header,
  output logic block_valid,
  output tts_pkg::tts_block_t block_status,
  // adc words toward the buffer memory
  output logic adc_word_valid,
  output logic [31:0] adc_word,
  // interrupt
  output logic irq
);

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  logic run_q;
  logic two_pulse_q;
  tts_pkg::tts_mode_t mode_q;
  logic [15:0] table_len_q;
  logic [31:0] fpb_q;
  logic [15:0] trig_div_q;
  logic [31:0] adc_cycles_q;
  logic [tts_pkg::IRQ_W-1:0] irq_sts_q;
  logic [tts_pkg::IRQ_W-1:0] irq_en_q;
  logic [31:0] rdata_q;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  wire wr_ctrl = reg_wr && hit(reg_addr, tts_pkg::OFS_CTRL);
  wire wr_len = reg_wr && hit(reg_addr, tts_pkg::OFS_TABLE_LEN);
  wire wr_fpb = reg_wr && hit(reg_addr, tts_pkg::OFS_FRAMES_PER_BLOCK);
  wire wr_div = reg_wr && hit(reg_addr, tts_pkg::OFS_TRIG_DIV);
  wire wr_adc = reg_wr && hit(reg_addr, tts_pkg::OFS_ADC_CYCLES);
  wire wr_clr = reg_wr && hit(reg_addr, tts_pkg::OFS_IRQ_CLEAR);
  wire wr_en = reg_wr && hit(reg_addr, tts_pkg::OFS_IRQ_ENABLE);
  wire adc_arm = wr_ctrl && reg_wdata[tts_pkg::CTRL_ADC_ARM_BIT];
  wire [1:0] wr_mode = reg_wdata[tts_pkg::CTRL_MODE_LSB +: 2];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      run_q <= 1'b0;
      two_pulse_q <= 1'b0;
      mode_q <= tts_pkg::MODE_NORMAL;
      table_len_q <= tts_pkg::TABLE_LEN_RST;
      fpb_q <= tts_pkg::FRAMES_PER_BLOCK_RST;
      trig_div_q <= tts_pkg::TRIG_DIV_RST;
      adc_cycles_q <= tts_pkg::ADC_CYCLES_RST;
      irq_en_q <= '0;
    end else begin
      if (wr_ctrl) begin
        run_q <= reg_wdata[tts_pkg::CTRL_RUN_BIT];
        two_pulse_q <= reg_wdata[tts_pkg::CTRL_TWO_PULSE_BIT];
        mode_q <= (wr_mode == 2'h2) ? tts_pkg::MODE_NORMAL : tts_pkg::tts_mode_t'(wr_mode);
      end
      if (wr_len) begin
        table_len_q <= reg_wdata[15:0];
      end
      if (wr_fpb) begin
        fpb_q <= reg_wdata;
      end
      if (wr_div) begin
        trig_div_q <= reg_wdata[15:0];
      end
      if (wr_adc) begin
        adc_cycles_q <= reg_wdata;
      end
      if (wr_en) begin
        irq_en_q <= reg_wdata[tts_pkg::IRQ_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // modulation cycle and frame index
  // ----------------------------------------
  logic [17:0] mod_cnt_q;
  logic [63:0] frame_idx_q;
  wire [17:0] mod_len = 18'(table_len_q) * 18'(tts_pkg::MOD_CLKS_PER_ENTRY);
  wire [17:0] mod_last = (table_len_q == 16'h0000) ? 18'h00000 : mod_len - 18'h00001;
  wire mod_wrap = (mod_cnt_q >= mod_last);
  wire [17:0] half_point = {1'b0, table_len_q, 1'b0};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mod_cnt_q <= 18'h00000;
      frame_idx_q <= 64'h0000_0000_0000_0000;
    end else begin
      mod_cnt_q <= mod_wrap ? 18'h00000 : mod_cnt_q + 18'h00001;
      if (mod_wrap) begin
        frame_idx_q <= frame_idx_q + 64'h0000_0000_0000_0001;
      end
    end
  end

  // ----------------------------------------
  // trigger clock and pin
  // ----------------------------------------
  logic [1:0] pre_q;
  logic [15:0] div_cnt_q;
  logic [31:0] trig_cnt_q;
  logic trig_s1_q;
  logic trig_s2_q;
  logic trig_s3_q;
  wire pre_tick = (pre_q == 2'(tts_pkg::TRIG_PRESCALE - 1));
  wire trig_tick = pre_tick && (div_cnt_q >= trig_div_q);
  wire trig_edge = trig_s2_q && !trig_s3_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pre_q <= 2'h0;
      div_cnt_q <= 16'h0000;
      trig_cnt_q <= 32'h0000_0000;
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_s3_q <= 1'b0;
    end else begin
      pre_q <= pre_q + 2'h1;
      if (pre_tick) begin
        div_cnt_q <= trig_tick ? 16'h0000 : div_cnt_q + 16'h0001;
      end
      if (trig_tick) begin
        trig_cnt_q <= trig_cnt_q + 32'h0000_0001;
      end
      trig_s1_q <= trigger_in;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
    end
  end

  // ----------------------------------------
  // acquisition, frames and blocks
  // ----------------------------------------
  tts_pkg::tts_acq_t acq_q;
  logic [31:0] frame_in_blk_q;
  logic [63:0] blk_first_q;
  logic trig_seen_q;
  logic [31:0] trig_ts_q;
  logic hdr_valid_q;
  tts_pkg::tts_header_t hdr_q;
  logic blk_valid_q;
  tts_pkg::tts_block_t blk_q;
  logic frame_q;
  logic pulse_q;
  wire running = (acq_q == tts_pkg::ACQ_RUN);
  wire acq_start = (acq_q == tts_pkg::ACQ_IDLE) && run_q;
  wire first_frame = (acq_q == tts_pkg::ACQ_WAIT) && mod_wrap;
  wire blk_end = running && mod_wrap && (frame_in_blk_q >= fpb_q - 32'h0000_0001);
  wire trig_in_blk = running && trig_edge;
  wire [63:0] next_frame = frame_idx_q + 64'h0000_0000_0000_0001;
  wire second_pulse = two_pulse_q && (mod_cnt_q == half_point);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      acq_q <= tts_pkg::ACQ_IDLE;
      frame_in_blk_q <= 32'h0000_0000;
      blk_first_q <= 64'h0000_0000_0000_0000;
      hdr_valid_q <= 1'b0;
      hdr_q <= '0;
      frame_q <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      hdr_valid_q <= acq_start;
      frame_q <= (first_frame || running) && mod_wrap;
      pulse_q <= ((first_frame || running) && mod_wrap) || (running && second_pulse);
      if (acq_start) begin
        hdr_q <= {tts_pkg::MASTER_CLOCK_X16_HZ, table_len_q, two_pulse_q ? 2'h2 : 2'h1, fpb_q};
      end
      case (acq_q)
        tts_pkg::ACQ_IDLE: begin
          if (run_q) begin
            acq_q <= tts_pkg::ACQ_WAIT;
          end
        end
        tts_pkg::ACQ_WAIT: begin
          if (mod_wrap) begin
            acq_q <= tts_pkg::ACQ_RUN;
            blk_first_q <= next_frame;
            frame_in_blk_q <= 32'h0000_0000;
          end
        end
        tts_pkg::ACQ_RUN: begin
          if (blk_end) begin
            acq_q <= run_q ? tts_pkg::ACQ_RUN : tts_pkg::ACQ_IDLE;
            blk_first_q <= next_frame;
            frame_in_blk_q <= 32'h0000_0000;
          end else if (mod_wrap) begin
            frame_in_blk_q <= frame_in_blk_q + 32'h0000_0001;
          end
        end
        default: begin
          acq_q <= tts_pkg::ACQ_IDLE;
        end
      endcase
    end
  end

  // an edge in the closing cycle belongs to the block that starts next
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      trig_seen_q <= 1'b0;
      trig_ts_q <= 32'h0000_0000;
      blk_valid_q <= 1'b0;
      blk_q <= '0;
    end else begin
      blk_valid_q <= blk_end;
      if (blk_end) begin
        blk_q <= {blk_first_q, trig_seen_q, trig_ts_q};
        trig_seen_q <= trig_edge;
      end else if (trig_in_blk) begin
        trig_seen_q <= 1'b1;
      end else if (!running) begin
        trig_seen_q <= 1'b0;
      end
      // first trigger of a block keeps its stamp
      if (trig_edge && (blk_end || (running && !trig_seen_q))) begin
        trig_ts_q <= trig_cnt_q;
      end
    end
  end

  // ----------------------------------------
  // adc test capture
  // ----------------------------------------
  tts_pkg::tts_adc_st_t adc_q;
  logic [31:0] adc_cyc_q;
  wire adc_capt = (adc_q == tts_pkg::ADC_CAPT);
  wire adc_done = adc_capt && mod_wrap && (adc_cyc_q >= adc_cycles_q - 32'h0000_0001);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      adc_q <= tts_pkg::ADC_IDLE;
      adc_cyc_q <= 32'h0000_0000;
    end else begin
      case (adc_q)
        tts_pkg::ADC_IDLE: begin
          if (adc_arm && (wr_mode == 2'(tts_pkg::MODE_ADC))) begin
            adc_q <= tts_pkg::ADC_ARMED;
          end
        end
        tts_pkg::ADC_ARMED: begin
          if (mode_q != tts_pkg::MODE_ADC) begin
            adc_q <= tts_pkg::ADC_IDLE;
          end else if (trig_edge) begin
            adc_q <= tts_pkg::ADC_CAPT;
            adc_cyc_q <= 32'h0000_0000;
          end
        end
        tts_pkg::ADC_CAPT: begin
          if (adc_done) begin
            adc_q <= tts_pkg::ADC_IDLE;
          end else if (mod_wrap) begin
            adc_cyc_q <= adc_cyc_q + 32'h0000_0001;
          end
        end
        default: begin
          adc_q <= tts_pkg::ADC_IDLE;
        end
      endcase
    end
  end

  tts_adc_pack u_pack (
    .clk(clk),
    .reset(reset),
    .enable(adc_capt),
    .smp(adc_in),
    .word_valid(adc_word_valid),
    .word(adc_word)
  );

  // ----------------------------------------
  // interrupt status
  // ----------------------------------------
  wire [tts_pkg::IRQ_W-1:0] irq_evt = {adc_done, trig_in_blk, blk_end};
  wire [tts_pkg::IRQ_W-1:0] irq_clr = wr_clr ? reg_wdata[tts_pkg::IRQ_W-1:0] : '0;

  // a set in the clearing cycle wins
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_sts_q <= '0;
    end else begin
      irq_sts_q <= (irq_sts_q & ~irq_clr) | irq_evt;
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    case (reg_addr)
      tts_pkg::OFS_CTRL: rd_mux = {28'h0, two_pulse_q, mode_q, run_q};
      tts_pkg::OFS_TABLE_LEN: rd_mux = {16'h0000, table_len_q};
      tts_pkg::OFS_FRAMES_PER_BLOCK: rd_mux = fpb_q;
      tts_pkg::OFS_TRIG_DIV: rd_mux = {16'h0000, trig_div_q};
      tts_pkg::OFS_ADC_CYCLES: rd_mux = adc_cycles_q;
      tts_pkg::OFS_IRQ_STATUS: rd_mux = {29'h0, irq_sts_q};
      tts_pkg::OFS_IRQ_ENABLE: rd_mux = {29'h0, irq_en_q};
      tts_pkg::OFS_FRAME_LO: rd_mux = frame_idx_q[31:0];
      tts_pkg::OFS_FRAME_HI: rd_mux = frame_idx_q[63:32];
      tts_pkg::OFS_TRIG_COUNT: rd_mux = trig_cnt_q;
      tts_pkg::OFS_CLK_X16: rd_mux = tts_pkg::MASTER_CLOCK_X16_HZ;
      tts_pkg::OFS_STATE: rd_mux = {28'h0, adc_q, acq_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata = rdata_q;
  assign frame_strobe = frame_q;
  assign pulse_strobe = pulse_q;
  assign raw_pair_sel = (mode_q == tts_pkg::MODE_RAW);
  assign header_valid = hdr_valid_q;
  assign header = hdr_q;
  assign block_valid = blk_valid_q;
  assign block_status = blk_q;
  assign irq = |(irq_sts_q & irq_en_q);

endmodule
`default_nettype wire

// *** tb/tts_top_sva.sv ***
// port timing checker for tts_top
// assumes length and block size are set before run
`timescale 1ns/1ps
`default_nettype none
module tts_top_sva (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // stream
  input wire logic frame_strobe,
  input wire logic pulse_strobe,
  input wire logic header_valid,
  input wire tts_pkg::tts_header_t header,
  input wire logic block_valid,
  input wire tts_pkg::tts_block_t block_status,
  input wire logic adc_word_valid
);
  // ----------------------------------------
  // shadow of programmed values
  // ----------------------------------------
  logic [15:0] len_q;
  logic [31:0] fpb_q;
  logic [31:0] gap_q;
  logic [63:0] ffi_q;
  logic two_q;
  logic fseen_q;
  logic bseen_q;
  wire ctrl_wr = reg_wr && reg_addr == tts_pkg::OFS_CTRL;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      len_q <= tts_pkg::TABLE_LEN_RST;
      fpb_q <= tts_pkg::FRAMES_PER_BLOCK_RST;
      gap_q <= 32'h0;
      ffi_q <= 64'h0;
      two_q <= 1'b0;
      fseen_q <= 1'b0;
      bseen_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == tts_pkg::OFS_TABLE_LEN) len_q <= reg_wdata[15:0];
      if (reg_wr && reg_addr == tts_pkg::OFS_FRAMES_PER_BLOCK) fpb_q <= reg_wdata;
      if (ctrl_wr) two_q <= reg_wdata[tts_pkg::CTRL_TWO_PULSE_BIT];
      gap_q <= frame_strobe ? 32'h1 : gap_q + 32'h1;
      // a ctrl write may restart the run, so spacing history is dropped
      fseen_q <= !ctrl_wr && (frame_strobe || fseen_q);
      bseen_q <= !ctrl_wr && (block_valid || bseen_q);
      if (block_valid) ffi_q <= block_status.first_frame_index;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  rd_idle_zero_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero outside read cycle");
  clk_x16_read_a: assert property (
    reg_rd && reg_addr == tts_pkg::OFS_CLK_X16 |=> reg_rdata == tts_pkg::MASTER_CLOCK_X16_HZ)
    else $error("clock x16 readback wrong");
  hdr_fields_a: assert property (
    header_valid |-> header.master_clock_x16_hz == tts_pkg::MASTER_CLOCK_X16_HZ
      && header.timing_table_length == len_q && header.frames_per_block == fpb_q
      && header.pulses_per_pass == (two_q ? 2'h2 : 2'h1))
    else $error("header fields wrong");
  hdr_pulse_a: assert property (header_valid |=> !header_valid)
    else $error("header valid longer than one cycle");
  frame_gap_a: assert property (frame_strobe && fseen_q |-> gap_q == 32'(len_q) * 32'h4)
    else $error("frame spacing not one modulation cycle");
  block_step_a: assert property (
    block_valid && bseen_q |-> block_status.first_frame_index == ffi_q + 64'(fpb_q))
    else $error("block first frame index step wrong");
  frame_pulse_a: assert property (frame_strobe |-> pulse_strobe)
    else $error("frame without pulse");
  extra_pulse_a: assert property (pulse_strobe && !frame_strobe |-> $past(two_q))
    else $error("second pulse without two-pulse setting");
  blk_pulse_a: assert property (block_valid |=> !block_valid)
    else $error("block valid longer than one cycle");
  adc_space_a: assert property (adc_word_valid |=> !adc_word_valid [*3])
    else $error("adc words closer than four clocks");

  hdr_c: cover property (header_valid);
  trig_blk_c: cover property (block_valid && block_status.trigger_seen_flag);
  adc_c: cover property (adc_word_valid);
  frame_c: cover property (frame_strobe && fseen_q);
endmodule

bind tts_top tts_top_sva tts_top_sva_i (
  .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_strobe(frame_strobe), .pulse_strobe(pulse_strobe),
  .header_valid(header_valid), .header(header), .block_valid(block_valid),
  .block_status(block_status), .adc_word_valid(adc_word_valid)
);
`default_nettype wire

// *** tb/tts_host_model.sv ***
// host side of the stream: keeps last block record and counts words
// assumes records are taken on the cycle their valid is high
`timescale 1ns/1ps
`default_nettype none
module tts_host_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // stream records
  input wire logic block_valid,
  input wire tts_pkg::tts_block_t block_status,
  input wire logic adc_word_valid,
  // received
  output var tts_pkg::tts_block_t blk_q,
  output logic [31:0] n_blocks_q,
  output logic [31:0] n_words_q
);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      blk_q <= '0;
      n_blocks_q <= 32'h0;
      n_words_q <= 32'h0;
    end else begin
      // one record per block, flag read only with its own block
      if (block_valid) blk_q <= block_status;
      if (block_valid) n_blocks_q <= n_blocks_q + 32'h1;
      // buffered words, drained later by the host
      if (adc_word_valid) n_words_q <= n_words_q + 32'h1;
    end
  end
endmodule
`default_nettype wire

// *** tb/test_trigger_timestamp_adc_packer.sv ***
// register-driven bench for tts_top with a host model
// assumes one 100 MHz clock; divisor shortened to 4 to keep runs short
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module test_trigger_timestamp_adc_packer;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic trigger_in = 1'b0;
  tts_pkg::tts_adc_smp_t adc_in = '0;
  logic [13:0] smp_cnt = 14'h0;
  logic [31:0] reg_rdata, adc_word, n_blocks, n_words, c1, c2, k;
  logic frame_strobe, pulse_strobe, raw_pair_sel, header_valid, block_valid, adc_word_valid, irq;
  tts_pkg::tts_header_t header;
  tts_pkg::tts_block_t block_status, blk;
  logic [63:0] ffi0;
  int fail_count = 0;
  int n_checks = 0;

  always #5 clk = ~clk;
  // ramp feed: flags copy low count bits so field positions show
  always @(posedge clk) begin
    smp_cnt <= smp_cnt + 14'h1;
    adc_in <= {smp_cnt[4], smp_cnt[3], smp_cnt[2], smp_cnt};
  end

  tts_top tts_top_i (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trigger_in(trigger_in), .adc_in(adc_in),
    .frame_strobe(frame_strobe), .pulse_strobe(pulse_strobe), .raw_pair_sel(raw_pair_sel),
    .header_valid(header_valid), .header(header), .block_valid(block_valid),
    .block_status(block_status), .adc_word_valid(adc_word_valid), .adc_word(adc_word), .irq(irq)
  );
  tts_host_model tts_host_model_i (
    .clk(clk), .reset(reset), .block_valid(block_valid), .block_status(block_status),
    .adc_word_valid(adc_word_valid), .blk_q(blk), .n_blocks_q(n_blocks), .n_words_q(n_words)
  );

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    `CHK(nm, e, v)
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // 0 header, 1 block end, 2 adc word, 3 frame, 4 irq
  task automatic wait_for(input int w);
    logic s;
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk);
      s = w == 0 ? header_valid : w == 1 ? block_valid : w == 2 ? adc_word_valid : w == 3 ? frame_strobe : irq;
      if (s === 1'b1) return;
    end
    fail_count++;
    $display("[FAIL] wait %0d expected 1 seen 0", w);
    close_out();
  endtask
  task automatic trig();
    @(posedge clk);
    trigger_in <= 1'b1;
    repeat (6) @(posedge clk);
    trigger_in <= 1'b0;
  endtask
  task automatic next_blk();
    wait_for(1);
    @(posedge clk);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    rchk("frame index", tts_pkg::OFS_FRAME_LO, 32'h0);
    rchk("trigger count", tts_pkg::OFS_TRIG_COUNT, 32'h0);
    rchk("divisor", tts_pkg::OFS_TRIG_DIV, 32'h0000_0018);
    rchk("clock x16", tts_pkg::OFS_CLK_X16, 32'h5F5E_1000);
    rchk("unmapped", 8'h3C, 32'h0);
    rchk("frame index hi", tts_pkg::OFS_FRAME_HI, 32'h0);
    $display("test reset values done");
    // 300 clocks between the two reads: 3 cycles of 100, 15 ticks of 20
    wr(tts_pkg::OFS_TRIG_DIV, 32'h4);
    rd(tts_pkg::OFS_FRAME_LO, c1);
    repeat (297) @(posedge clk);
    rd(tts_pkg::OFS_FRAME_LO, c2);
    `CHK("frame delta", 32'h3, c2 - c1)
    rd(tts_pkg::OFS_TRIG_COUNT, c1);
    repeat (297) @(posedge clk);
    rd(tts_pkg::OFS_TRIG_COUNT, c2);
    `CHK("tick delta", 32'hF, c2 - c1)
    $display("test time base done");
    wr(tts_pkg::OFS_FRAMES_PER_BLOCK, 32'h4);
    wr(tts_pkg::OFS_IRQ_ENABLE, 32'h7);
    wr(tts_pkg::OFS_CTRL, 32'h9);
    wait_for(0);
    `CHK("header pulses", 2'h2, header.pulses_per_pass)
    `CHK("header length", 16'h0019, header.timing_table_length)
    wait_for(3);
    k = 32'h0;
    repeat (100) begin
      @(posedge clk);
      if (pulse_strobe === 1'b1) k++;
    end
    `CHK("pulses per cycle", 32'h2, k)
    wait_for(1);
    rd(tts_pkg::OFS_TRIG_COUNT, c1);
    trig();
    rd(tts_pkg::OFS_TRIG_COUNT, c2);
    repeat (20) @(posedge clk);
    trig();
    next_blk();
    `CHK("flag set", 1'b1, blk.trigger_seen_flag)
    `CHK("first stamp kept", 1'b1, blk.trigger_timestamp >= c1 && blk.trigger_timestamp <= c2)
    ffi0 = blk.first_frame_index;
    `CHK("irq raised", 1'b1, irq)
    rchk("irq status", tts_pkg::OFS_IRQ_STATUS, 32'h3);
    wr(tts_pkg::OFS_IRQ_CLEAR, 32'h3);
    @(posedge clk);
    `CHK("irq cleared", 1'b0, irq)
    next_blk();
    `CHK("flag quiet block", 1'b0, blk.trigger_seen_flag)
    `CHK("block index step", ffi0 + 64'h4, blk.first_frame_index)
    trig();
    next_blk();
    `CHK("flag later block", 1'b1, blk.trigger_seen_flag)
    wr(tts_pkg::OFS_IRQ_ENABLE, 32'h0);
    @(posedge clk);
    `CHK("irq masked", 1'b0, irq)
    wr(tts_pkg::OFS_CTRL, 32'h0);
    wait_for(1);
    rchk("acq idle", tts_pkg::OFS_STATE, 32'h0);
    wr(tts_pkg::OFS_CTRL, 32'h2);
    @(posedge clk);
    `CHK("raw select", 1'b1, raw_pair_sel)
    $display("test acquisition done");
    wr(tts_pkg::OFS_ADC_CYCLES, 32'h2);
    wr(tts_pkg::OFS_IRQ_ENABLE, 32'h4);
    wr(tts_pkg::OFS_CTRL, 32'h16);
    rchk("adc armed", tts_pkg::OFS_STATE, 32'h4);
    trig();
    wait_for(2);
    repeat (4) begin
      `CHK("high sample", adc_word[13:0] + 14'h2, adc_word[29:16])
      `CHK("low flags", adc_word[3:2], adc_word[15:14])
      `CHK("high flags", {adc_word[20], adc_word[18]}, adc_word[31:30])
      repeat (4) @(posedge clk);
      `CHK("word rate", 1'b1, adc_word_valid)
    end
    wait_for(4);
    rchk("adc done", tts_pkg::OFS_STATE, 32'h0);
    k = n_words;
    trig();
    repeat (200) @(posedge clk);
    `CHK("single capture", k, n_words)
    `CHK("blocks after stop", 32'h5, n_blocks)
    $display("test adc capture done");
    close_out();
  end
endmodule
`default_nettype wire
